// ===== rtl/wit_pkg.sv
package wit_pkg;

   // Register addresses and write keys.
   localparam logic [31:0] WIT_ADDR_COUNT  = 32'hFFFF_FF84;
   localparam logic [31:0] WIT_ADDR_CTRL   = 32'hFFFF_FF86;
   localparam logic [7:0]  WIT_KEY_COUNT   = 8'h5A;
   localparam logic [7:0]  WIT_KEY_CTRL    = 8'hA5;

   // Field positions of watchdog_ctrl_status.
   localparam int WIT_BIT_ENABLE = 7;
   localparam int WIT_BIT_MODE   = 6;
   localparam int WIT_BIT_RSTSEL = 5;
   localparam int WIT_BIT_WDFLAG = 4;
   localparam int WIT_BIT_IVFLAG = 3;
   localparam int WIT_CLKSEL_LSB = 0;

   // Reset values and count marks.
   localparam logic [7:0] WIT_CTRL_RESET  = 8'h00;
   localparam logic [7:0] WIT_COUNT_RESET = 8'h00;
   localparam logic [7:0] WIT_COUNT_MAX   = 8'hFF;
   localparam logic [7:0] WIT_COUNT_REARM = 8'h80;

   // Status pin encodings.
   localparam logic [1:0] WIT_STATUS_RUN   = 2'h0;
   localparam logic [1:0] WIT_STATUS_RESET = 2'h3;

   // Width of the internal reset pulse.
   localparam int           WIT_RST_PULSE_NS  = 320;
   localparam int           WIT_CLK_PERIOD_NS = 20;
   localparam logic [4:0]   WIT_RST_CYCLES    =
      5'((WIT_RST_PULSE_NS + WIT_CLK_PERIOD_NS - 1) / WIT_CLK_PERIOD_NS);

   // Access sizes on the register port.
   typedef enum logic [1:0] {
      WIT_SZ_BYTE = 2'b00,
      WIT_SZ_WORD = 2'b01,
      WIT_SZ_LONG = 2'b10
   } wit_size_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      wit_size_t   size;
      logic [31:0] addr;
      logic [15:0] wdata;
   } wit_req_t;

   typedef enum logic [2:0] {
      WIT_ST_NORMAL  = 3'b000,
      WIT_ST_STANDBY = 3'b001,
      WIT_ST_SETTLE  = 3'b010,
      WIT_ST_AFTER   = 3'b011,
      WIT_ST_FREQ    = 3'b100,
      WIT_ST_LOCKED  = 3'b101
   } wit_state_t;

endpackage

// ===== rtl/wit_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module wit_prescaler import wit_pkg::*; #(
   parameter int DIV_W = 12
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [2:0] sel,
   output var  logic       tick
);

   logic [DIV_W-1:0] div_count;

   // Mask of low divider bits that must all be ones for one tick.
   function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] s);
      unique case (s)
         3'h0: div_mask = DIV_W'(12'h000);
         3'h1: div_mask = DIV_W'(12'h003);
         3'h2: div_mask = DIV_W'(12'h00F);
         3'h3: div_mask = DIV_W'(12'h01F);
         3'h4: div_mask = DIV_W'(12'h03F);
         3'h5: div_mask = DIV_W'(12'h0FF);
         3'h6: div_mask = DIV_W'(12'h3FF);
         3'h7: div_mask = DIV_W'(12'hFFF);
      endcase
   endfunction

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_count <= '0;
      end else begin
         div_count <= div_count + DIV_W'(1);
      end
   end

   // The divider runs free, so a select change mid-count can shorten one period.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick <= 1'b0;
      end else begin
         tick <= ((div_count & div_mask(sel)) == div_mask(sel));
      end
   end

endmodule

`default_nettype wire

// ===== rtl/wit_timer.sv
// Operation
// - Enable bit 0 freezes the count; 1 lets it advance on count clock (code counts regardless of it in settle, after-settle and frequency states).
// - Mode bit 0 selects interval timer, 1 selects watchdog.
// - In watchdog mode reset select chooses power-on (0) or manual (1).
// - Overflow reset drives reset output low and status pins to reset code.
// - Watchdog flag sets only on overflow in watchdog mode.
// - Interval flag sets only on overflow in interval mode.
// - Clock select divides peripheral clock by 1,4,16,32,64,256,1024,4096.
// - Only word writes with key 5A/A5 in upper byte store low byte.
// - In standby, counting begins on a cancelling interrupt or NMI edge.
// - Settling overflow resumes clocks and leaves the watchdog flag clear.
// - Count continues from 00; at 80 with standby still set, lock standby.
// - Frequency register write stops clock and counts; overflow resumes clocks.
// - After frequency change the counter is set to 00 and stops there while the enable bit is clear.
// - Watchdog overflow sets flag, raises chosen reset, keeps counting.
// - Interval overflow sets flag, requests interrupt, keeps counting.
// - Counter is eight bits, read/write, one step per count clock pulse.
// - Only power-on reset clears control register; own reset keeps it.
`timescale 1ns/1ps
`default_nettype none

module wit_timer import wit_pkg::*; #(
   parameter int         DIV_W      = 12,
   parameter logic [4:0] RST_CYCLES = WIT_RST_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire wit_req_t   req,
   output var  logic [7:0] rd_data,
   output var  logic       rd_valid,
   input  wire logic       standby_enter,
   input  wire logic       standby_cancel_in,
   input  wire logic       standby_request_bit,
   input  wire logic       freq_write,
   output var  logic       clock_resume,
   output var  logic       standby_reenter,
   output var  logic       standby_locked,
   output var  logic       interval_irq,
   output var  logic       reset_out_n,
   output var  logic       por_req,
   output var  logic       manual_req,
   output var  logic       status_out_0,
   output var  logic       status_out_1
);

   logic [7:0]  watchdog_count;
   logic [7:0]  watchdog_ctrl_status;
   wit_state_t  state;
   wit_state_t  next_state;
   logic        tick;
   logic        cancel_s1;
   logic        cancel_s2;
   logic        cancel_s3;
   logic        cancel_edge;
   logic        wr_count_ok;
   logic        wr_ctrl_ok;
   logic        counting;
   logic        overflow;
   logic        wd_overflow;
   logic        iv_overflow;
   logic [4:0]  rst_timer;

   wire logic       count_enable        = watchdog_ctrl_status[WIT_BIT_ENABLE];
   wire logic       timer_mode_select   = watchdog_ctrl_status[WIT_BIT_MODE];
   wire logic       reset_type_select   = watchdog_ctrl_status[WIT_BIT_RSTSEL];
   wire logic [2:0] count_clock_select  =
      watchdog_ctrl_status[WIT_CLKSEL_LSB +: 3];

   wit_prescaler #(
      .DIV_W (DIV_W)
   ) u_prescaler (
      .clk  (clk),
      .nrst (nrst),
      .sel  (count_clock_select),
      .tick (tick)
   );

   // Cancel source arrives from outside the clock domain.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cancel_s1 <= 1'b0;
         cancel_s2 <= 1'b0;
         cancel_s3 <= 1'b0;
      end else begin
         cancel_s1 <= standby_cancel_in;
         cancel_s2 <= cancel_s1;
         cancel_s3 <= cancel_s2;
      end
   end

   assign cancel_edge = cancel_s2 ^ cancel_s3;

   // Wrong size or key is silently dropped; there is no error response.
   assign wr_count_ok = req.wr && (req.size == WIT_SZ_WORD) &&
                        (req.addr == WIT_ADDR_COUNT) &&
                        (req.wdata[15:8] == WIT_KEY_COUNT);
   assign wr_ctrl_ok  = req.wr && (req.size == WIT_SZ_WORD) &&
                        (req.addr == WIT_ADDR_CTRL) &&
                        (req.wdata[15:8] == WIT_KEY_CTRL);

   // Settling and frequency counts run even with the enable bit clear.
   always_comb begin
      unique case (state)
         WIT_ST_NORMAL: counting = count_enable;
         WIT_ST_SETTLE: counting = 1'b1;
         WIT_ST_AFTER:  counting = 1'b1;
         WIT_ST_FREQ:   counting = 1'b1;
         default:       counting = 1'b0;
      endcase
   end

   assign overflow    = counting && tick &&
                        (watchdog_count == WIT_COUNT_MAX);
   assign wd_overflow = overflow && (state == WIT_ST_NORMAL) &&
                        timer_mode_select;
   assign iv_overflow = overflow && (state == WIT_ST_NORMAL) &&
                        !timer_mode_select;

   always_comb begin
      next_state = state;
      unique case (state)
         WIT_ST_NORMAL: begin
            if (freq_write) begin
               next_state = WIT_ST_FREQ;
            end else if (standby_enter) begin
               next_state = WIT_ST_STANDBY;
            end
         end
         WIT_ST_STANDBY: begin
            if (cancel_edge) begin
               next_state = WIT_ST_SETTLE;
            end
         end
         WIT_ST_SETTLE: begin
            if (overflow) begin
               next_state = WIT_ST_AFTER;
            end
         end
         WIT_ST_AFTER: begin
            if (!standby_request_bit) begin
               next_state = WIT_ST_NORMAL;
            end else if (watchdog_count == WIT_COUNT_REARM) begin
               next_state = WIT_ST_LOCKED;
            end
         end
         WIT_ST_FREQ: begin
            if (overflow) begin
               next_state = WIT_ST_NORMAL;
            end
         end
         WIT_ST_LOCKED: begin
            next_state = WIT_ST_LOCKED;
         end
         default: begin
            next_state = WIT_ST_NORMAL;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= WIT_ST_NORMAL;
      end else begin
         state <= next_state;
      end
   end

   // Counter: a keyed write wins over a count step in the same cycle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         watchdog_count <= WIT_COUNT_RESET;
      end else if (wr_count_ok) begin
         watchdog_count <= req.wdata[7:0];
      end else if (state == WIT_ST_FREQ && overflow) begin
         watchdog_count <= WIT_COUNT_RESET;
      end else if (counting && tick) begin
         watchdog_count <= watchdog_count + 8'h01;
      end
   end

   // Control register: only nrst clears it, never the overflow reset.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         watchdog_ctrl_status <= WIT_CTRL_RESET;
      end else begin
         if (wr_ctrl_ok) begin
            watchdog_ctrl_status <= req.wdata[7:0];
         end
         // Hardware set wins over a software clear in the same cycle.
         if (wd_overflow) begin
            watchdog_ctrl_status[WIT_BIT_WDFLAG] <= 1'b1;
         end
         if (iv_overflow) begin
            watchdog_ctrl_status[WIT_BIT_IVFLAG] <= 1'b1;
         end
      end
   end

   // Byte reads return the register one cycle after the request.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= req.rd;
         if (req.rd && req.addr == WIT_ADDR_COUNT) begin
            rd_data <= watchdog_count;
         end else if (req.rd && req.addr == WIT_ADDR_CTRL) begin
            rd_data <= watchdog_ctrl_status;
         end else begin
            rd_data <= 8'h00;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         interval_irq <= 1'b0;
      end else begin
         interval_irq <= iv_overflow;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clock_resume <= 1'b0;
      end else begin
         clock_resume <= overflow && ((state == WIT_ST_SETTLE) ||
                         (state == WIT_ST_FREQ));
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         standby_reenter <= 1'b0;
      end else begin
         standby_reenter <= (state == WIT_ST_AFTER) &&
                            (next_state == WIT_ST_LOCKED);
      end
   end

   // Once locked, only the power-on reset pin brings the block back.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         standby_locked <= 1'b0;
      end else begin
         standby_locked <= (next_state == WIT_ST_LOCKED);
      end
   end

   // Reset pulse lasts RST_CYCLES so the system reset tree can see it.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_timer <= 5'h00;
      end else if (wd_overflow) begin
         rst_timer <= RST_CYCLES;
      end else if (rst_timer != 5'h00) begin
         rst_timer <= rst_timer - 5'h01;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reset_out_n <= 1'b1;
      end else if (wd_overflow) begin
         reset_out_n <= 1'b0;
      end else if (rst_timer == 5'h01) begin
         reset_out_n <= 1'b1;
      end
   end

   // Exactly one of the two requests stands while the pulse is low.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         por_req    <= 1'b0;
         manual_req <= 1'b0;
      end else if (wd_overflow) begin
         por_req    <= !reset_type_select;
         manual_req <= reset_type_select;
      end else if (rst_timer == 5'h01) begin
         por_req    <= 1'b0;
         manual_req <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_out_0 <= WIT_STATUS_RUN[0];
         status_out_1 <= WIT_STATUS_RUN[1];
      end else if (wd_overflow) begin
         status_out_0 <= WIT_STATUS_RESET[0];
         status_out_1 <= WIT_STATUS_RESET[1];
      end else if (rst_timer == 5'h01) begin
         status_out_0 <= WIT_STATUS_RUN[0];
         status_out_1 <= WIT_STATUS_RUN[1];
      end
   end

endmodule

`default_nettype wire

// ===== bench/wit_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none

module wit_timer_chk import wit_pkg::*; #(
   parameter logic [4:0] RST_CYCLES = WIT_RST_CYCLES
) (
   input  wire logic     clk,
   input  wire logic     nrst,
   input  wire wit_req_t req,
   input  wire logic     rd_valid,
   input  wire logic     clock_resume,
   input  wire logic     standby_reenter,
   input  wire logic     standby_locked,
   input  wire logic     interval_irq,
   input  wire logic     reset_out_n,
   input  wire logic     por_req,
   input  wire logic     manual_req,
   input  wire logic     status_out_0,
   input  wire logic     status_out_1
);
   logic       rd_q;
   logic [4:0] low_cnt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) rd_q <= 1'b0;
      else rd_q <= req.rd;
   end

   // Five bits hold any pulse length we configure, so no wrap is seen.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) low_cnt <= 5'h00;
      else low_cnt <= reset_out_n ? 5'h00 : low_cnt + 5'h01;
   end

   a_rd_answer: assert property (req.rd |=> rd_valid)
      else $error("read not answered");
   a_rd_only: assert property (rd_valid |-> rd_q)
      else $error("read answer without request");
   a_rst_width: assert property (
      $rose(reset_out_n) |-> low_cnt == RST_CYCLES)
      else $error("reset pulse width wrong");
   a_reset_kind: assert property (
      !reset_out_n |-> por_req != manual_req)
      else $error("reset kind not single");
   a_reset_idle: assert property (
      reset_out_n |-> !(por_req || manual_req))
      else $error("reset request outside pulse");
   a_status_code: assert property (
      !reset_out_n |-> status_out_0 && status_out_1)
      else $error("status pins not in reset code");
   a_irq_single: assert property (interval_irq |=> !interval_irq)
      else $error("interval request longer than one cycle");
   a_one_event: assert property (
      interval_irq |-> !$fell(reset_out_n))
      else $error("both overflow kinds at once");
   a_lock_holds: assert property (
      standby_locked |=> standby_locked)
      else $error("standby lock released");
   a_lock_entry: assert property (
      standby_reenter |=> standby_locked)
      else $error("reentry without lock");
   a_resume_pulse: assert property (
      clock_resume |=> !clock_resume)
      else $error("clock resume longer than one cycle");

   c_irq: cover property (interval_irq);
   c_wdt: cover property ($fell(reset_out_n));
   c_resume: cover property (clock_resume);
   c_lock: cover property (standby_reenter);
endmodule

bind wit_timer wit_timer_chk #(.RST_CYCLES(RST_CYCLES)) u_chk (
   .clk(clk), .nrst(nrst), .req(req), .rd_valid(rd_valid),
   .clock_resume(clock_resume), .standby_reenter(standby_reenter),
   .standby_locked(standby_locked), .interval_irq(interval_irq),
   .reset_out_n(reset_out_n), .por_req(por_req), .manual_req(manual_req),
   .status_out_0(status_out_0), .status_out_1(status_out_1)
);

`default_nettype wire

// ===== bench/wit_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module wit_host_model (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       wake,
   input  wire logic       interval_irq,
   output var  logic       standby_cancel_in,
   output var  logic [7:0] irq_count
);
   // A wake flips the pin; the timer reacts to either edge of it.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) standby_cancel_in <= 1'b0;
      else if (wake) standby_cancel_in <= !standby_cancel_in;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) irq_count <= 8'h00;
      else if (interval_irq) irq_count <= irq_count + 8'h01;
   end
endmodule

`default_nettype wire

// ===== bench/wit_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none

module wit_timer_bench import wit_pkg::*;;
   typedef struct packed {
      wit_size_t   sz;
      logic [31:0] a;
      logic [15:0] d;
      logic [31:0] ra;
      logic [7:0]  x;
   } wit_row_t;
   logic       clk = 1'b0;
   logic nrst, rd_valid, standby_enter, standby_cancel_in;
   logic standby_request_bit, freq_write, wake, clock_resume;
   logic standby_reenter, standby_locked, interval_irq, reset_out_n;
   logic por_req, manual_req, status_out_0, status_out_1;
   logic [7:0] rd_data, irq_count;
   wit_req_t   req;
   int         num_errors, num_checks, n;
   int         sh [8] = '{0, 2, 4, 5, 6, 8, 10, 12};
   wit_row_t   rows [7] = '{
      '{WIT_SZ_WORD, WIT_ADDR_CTRL, 16'hA507, WIT_ADDR_CTRL, 8'h07},
      '{WIT_SZ_BYTE, WIT_ADDR_CTRL, 16'hA501, WIT_ADDR_CTRL, 8'h07},
      '{WIT_SZ_LONG, WIT_ADDR_CTRL, 16'hA501, WIT_ADDR_CTRL, 8'h07},
      '{WIT_SZ_WORD, WIT_ADDR_CTRL, 16'h5A01, WIT_ADDR_CTRL, 8'h07},
      '{WIT_SZ_WORD, WIT_ADDR_COUNT, 16'h5A3C, WIT_ADDR_COUNT, 8'h3C},
      '{WIT_SZ_WORD, WIT_ADDR_COUNT, 16'hA511, WIT_ADDR_COUNT, 8'h3C},
      '{WIT_SZ_WORD, 32'hFFFFFF88, 16'h5A11, 32'hFFFFFF88, 8'h00}};

   wit_timer uut (.clk(clk), .nrst(nrst), .req(req), .rd_data(rd_data),
      .rd_valid(rd_valid), .standby_enter(standby_enter),
      .standby_cancel_in(standby_cancel_in),
      .standby_request_bit(standby_request_bit), .freq_write(freq_write),
      .clock_resume(clock_resume), .standby_reenter(standby_reenter),
      .standby_locked(standby_locked), .interval_irq(interval_irq),
      .reset_out_n(reset_out_n), .por_req(por_req), .manual_req(manual_req),
      .status_out_0(status_out_0), .status_out_1(status_out_1));
   wit_host_model host (.clk(clk), .nrst(nrst), .wake(wake),
      .interval_irq(interval_irq), .standby_cancel_in(standby_cancel_in),
      .irq_count(irq_count));

   always #10 clk = ~clk;

   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      num_checks++;
      if (g !== x) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic wr(input wit_size_t s, input logic [31:0] a,
                     input logic [15:0] d);
      @(posedge clk) req <= '{1'b1, 1'b0, s, a, d};
      @(posedge clk) req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] x);
      @(posedge clk) req <= '{1'b0, 1'b1, WIT_SZ_BYTE, a, 16'h0000};
      @(posedge clk) req.rd <= 1'b0;
      #1 chk({7'h00, rd_valid, rd_data}, {8'h01, x});
   endtask
   function automatic logic hit(input int k);
      return k == 0 ? interval_irq : k == 1 ? !reset_out_n :
             k == 2 ? clock_resume : standby_reenter;
   endfunction
   // Bounded wait; running out is itself reported as a mismatch.
   task automatic till(input int k, input int lim, output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1 c++;
      end while (hit(k) !== 1'b1 && c < lim);
      chk({15'h0000, c < lim}, 16'h0001);
   endtask
   task automatic reset_dut();
      @(posedge clk) nrst <= 1'b0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
   endtask
   task automatic complete_run();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #1_500_000;
      num_errors++;
      complete_run();
   end

   initial begin
      nrst = 1'b0;
      req = '0;
      {standby_enter, standby_request_bit, freq_write, wake} = 4'h0;
      reset_dut();
      rd(WIT_ADDR_CTRL, 8'h00);
      rd(WIT_ADDR_COUNT, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].sz, rows[i].a, rows[i].d);
         rd(rows[i].ra, rows[i].x);
      end
      for (int c = 0; c < 8; c++) begin
         wr(WIT_SZ_WORD, WIT_ADDR_CTRL, 16'hA500);
         wr(WIT_SZ_WORD, WIT_ADDR_COUNT, 16'h5AFE);
         wr(WIT_SZ_WORD, WIT_ADDR_CTRL, {8'hA5, 5'b10000, 3'(c)});
         till(0, 20000, n);
         if (c < 4) begin
            till(0, 20000, n);
            chk(16'(n), 16'h0100 << sh[c]);
         end else begin
            // A slow tick is timed from FF; the reload eats two cycles.
            wr(WIT_SZ_WORD, WIT_ADDR_COUNT, 16'h5AFF);
            till(0, 20000, n);
            chk(16'(n + 2), 16'h0001 << sh[c]);
         end
         rd(WIT_ADDR_CTRL, {5'b10001, 3'(c)});
      end
      wr(WIT_SZ_WORD, WIT_ADDR_CTRL, 16'hA500);
      chk({8'h00, irq_count}, 16'h0010);
      for (int m = 0; m < 2; m++) begin
         wr(WIT_SZ_WORD, WIT_ADDR_COUNT, 16'h5AF0);
         wr(WIT_SZ_WORD, WIT_ADDR_CTRL, {8'hA5, 2'b11, 1'(m), 5'h00});
         till(1, 64, n);
         chk({por_req, manual_req}, m ? 16'h0001 : 16'h0002);
         chk({status_out_1, status_out_0}, 16'h0003);
         rd(WIT_ADDR_CTRL, {2'b11, 1'(m), 5'h10});
         wr(WIT_SZ_WORD, WIT_ADDR_CTRL, 16'hA500);
         repeat (20) @(posedge clk);
      end
      // Kicks come well inside one wrap, so no watchdog reset may occur.
      wr(WIT_SZ_WORD, WIT_ADDR_COUNT, 16'h5A00);
      wr(WIT_SZ_WORD, WIT_ADDR_CTRL, 16'hA5C0);
      repeat (3) begin
         repeat (200) @(posedge clk);
         wr(WIT_SZ_WORD, WIT_ADDR_COUNT, 16'h5A00);
      end
      rd(WIT_ADDR_CTRL, 8'hC0);
      chk({15'h0000, reset_out_n}, 16'h0001);
      wr(WIT_SZ_WORD, WIT_ADDR_CTRL, 16'hA500);
      wr(WIT_SZ_WORD, WIT_ADDR_COUNT, 16'h5AF0);
      @(posedge clk) begin
         standby_request_bit <= 1'b1;
         standby_enter <= 1'b1;
      end
      @(posedge clk) standby_enter <= 1'b0;
      repeat (5) @(posedge clk);
      @(posedge clk) wake <= 1'b1;
      @(posedge clk) wake <= 1'b0;
      till(2, 64, n);
      rd(WIT_ADDR_CTRL, 8'h00);
      till(3, 200, n);
      @(posedge clk) standby_request_bit <= 1'b0;
      #1 chk({15'h0000, standby_locked}, 16'h0001);
      reset_dut();
      #1 chk({15'h0000, standby_locked}, 16'h0000);
      wr(WIT_SZ_WORD, WIT_ADDR_COUNT, 16'h5AF0);
      @(posedge clk) freq_write <= 1'b1;
      @(posedge clk) freq_write <= 1'b0;
      till(2, 64, n);
      repeat (8) @(posedge clk);
      rd(WIT_ADDR_COUNT, 8'h00);
      rd(WIT_ADDR_CTRL, 8'h00);
      complete_run();
   end
endmodule

`default_nettype wire
